// File: core/dmadc_mover.v
// One element move: source read, then destination write.
// Assumes a memory port on clk that pulses mem_ack per access.
`default_nettype none
`include "dmadc_map.vh"

module dmadc_mover (
   input  wire        clk,
   input  wire        arst_n,
   input  wire        start,
   input  wire [31:0] src_addr,
   input  wire [31:0] dst_addr,
   input  wire [1:0]  src_size,
   input  wire [1:0]  dst_size,
   input  wire [1:0]  elem_size,
   output reg         done,
   output reg         err,
   output reg         mem_req,
   output reg         mem_write,
   output reg  [31:0] mem_addr,
   output reg  [1:0]  mem_size,
   output reg  [31:0] mem_wdata,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   input  wire        mem_err
);

localparam M_IDLE = 2'h0;
localparam M_RD   = 2'h1;
localparam M_WR   = 2'h2;

reg [1:0] state;

// Keeps only the element's bytes, whatever width was read
function [31:0] dmadc_mask;
   input [31:0] d;
   input [1:0]  sz;
   begin
      case (sz)
         `DMADC_SIZE_8:  dmadc_mask = {24'h000000, d[7:0]};
         `DMADC_SIZE_16: dmadc_mask = {16'h0000, d[15:0]};
         default:        dmadc_mask = d;
      endcase
   end
endfunction

always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      state     <= M_IDLE;
      done      <= 1'b0;
      err       <= 1'b0;
      mem_req   <= 1'b0;
      mem_write <= 1'b0;
      mem_addr  <= `DMADC_RST_WORD;
      mem_size  <= `DMADC_SIZE_8;
      mem_wdata <= `DMADC_RST_WORD;
   end else begin
      done <= 1'b0;
      case (state)
         M_IDLE: begin
            if (start) begin
               mem_req   <= 1'b1;
               mem_write <= 1'b0;
               mem_addr  <= src_addr;
               mem_size  <= src_size;
               state     <= M_RD;
            end
         end
         M_RD: begin
            if (mem_ack) begin
               if (mem_err) begin
                  // Failed read: no write is attempted
                  mem_req <= 1'b0;
                  done    <= 1'b1;
                  err     <= 1'b1;
                  state   <= M_IDLE;
               end else begin
                  mem_write <= 1'b1;
                  mem_addr  <= dst_addr;
                  mem_size  <= dst_size;
                  mem_wdata <= dmadc_mask(mem_rdata, elem_size);
                  state     <= M_WR;
               end
            end
         end
         M_WR: begin
            if (mem_ack) begin
               mem_req   <= 1'b0;
               mem_write <= 1'b0;
               done      <= 1'b1;
               err       <= mem_err;
               state     <= M_IDLE;
            end
         end
         default: state <= M_IDLE;
      endcase
   end
end

endmodule
`default_nettype wire

// File: core/dmadc_top.v
// One DMA channel: two descriptors, triggers, preemption, completion
// actions; registers behind an AXI4-Lite slave.
// Assumes engine_grant and preempt_req come from a decoder on clk;
// the trigger pin is asynchronous.
//
// Function
// - Each side accesses at element size or full word, chosen per side.
// - Address step equals that side's access width in bytes.
// - Source and destination stepping enabled independently; else address stays fixed.
// - Level trigger waits a programmed cycle count after service before retriggering.
// - Trigger dropping low during the wait ends it; next high retriggers.
// - Trigger high for whole wait retriggers when the count elapses.
// - Mode selects single element, whole descriptor, or whole descriptor plus auto-trigger.
// - Non-preemptable descriptor runs its transfer unit to completion uninterrupted.
// - Preemptable descriptor yields to a higher-priority channel between elements.
// - Preempted channel stays pending and resumes when granted again.
// - Descriptor completes only after its full element count moved.
// - Completion may chain, invalidate and raise interrupt, in any combination.
// - Chaining switches the channel to its other descriptor.
// - Status word shows validity, response code and current element index.
// - Element size field selects 8, 16 or 32 bit elements.
// - Element count field holds count minus one, covering 1 to 65536.
`default_nettype none
`include "dmadc_map.vh"

module dmadc_top (
   input  wire        clk,
   input  wire        arst_n,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        channel_trigger_input,
   input  wire        engine_grant,
   input  wire        preempt_req,
   output reg         chan_request,
   output reg         chan_active,
   output reg         complete_irq,
   output wire        mem_req,
   output wire        mem_write,
   output wire [31:0] mem_addr,
   output wire [1:0]  mem_size,
   output wire [31:0] mem_wdata,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   input  wire        mem_err
);

localparam S_IDLE = 1'b0;
localparam S_MOVE = 1'b1;

reg  [31:0] desc_src [0:1];
reg  [31:0] desc_dst [0:1];
reg  [31:0] desc_ctl [0:1];
reg         st_valid [0:1];
reg  [2:0]  st_resp  [0:1];
reg  [15:0] st_index [0:1];
reg         chan_enable;
reg         active_desc;
reg  [15:0] holdoff_cycles;
reg         state;
reg  [31:0] cur_src;
reg  [31:0] cur_dst;
reg         mv_start;
reg         trig_s1;
reg         trig_s2;
reg         trig_prev;
reg         hold_busy;
reg  [15:0] hold_cnt;
reg         auto_trig;
reg         sw_trig;
reg         aw_hold;
reg  [5:0]  aw_addr;
reg         w_hold;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
wire        mv_done;
wire        mv_err;
wire [31:0] ctl;
wire [1:0]  elem_size;
wire [1:0]  src_size;
wire [1:0]  dst_size;
wire [1:0]  mode;
wire        trig_event;
wire        do_write;
wire        wr_desc;
wire [3:0]  wr_word;
wire        last_elem;

// Access width in bytes, the stepping amount of one side
function [31:0] dmadc_step;
   input [1:0] sz;
   begin
      case (sz)
         `DMADC_SIZE_8:  dmadc_step = 32'h00000001;
         `DMADC_SIZE_16: dmadc_step = 32'h00000002;
         default:        dmadc_step = 32'h00000004;
      endcase
   end
endfunction

// Byte-lane merge of a bus write into a stored word
function [31:0] dmadc_merge;
   input [31:0] old;
   input [31:0] val;
   input [3:0]  strb;
   integer      i;
   begin
      dmadc_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
         if (strb[i]) begin
            dmadc_merge[i*8 +: 8] = val[i*8 +: 8];
         end
      end
   end
endfunction

function dmadc_mapped;
   input [5:0] a;
   begin
      dmadc_mapped = (a[5:2] <= 4'ha);
   end
endfunction

function [31:0] dmadc_status;
   input        v;
   input [2:0]  r;
   input [15:0] idx;
   begin
      dmadc_status = {v, 12'h000, r, idx};
   end
endfunction

assign ctl       = desc_ctl[active_desc];
assign elem_size = (ctl[`DMADC_CTL_ESIZE_LSB +: 2] == 2'h3) ? `DMADC_SIZE_32
                   : ctl[`DMADC_CTL_ESIZE_LSB +: 2];
// per side element or word width
assign src_size  = ctl[`DMADC_CTL_SRCW] ? `DMADC_SIZE_32 : elem_size;
assign dst_size  = ctl[`DMADC_CTL_DSTW] ? `DMADC_SIZE_32 : elem_size;
assign mode      = ctl[`DMADC_CTL_MODE_LSB +: 2];
assign last_elem = (st_index[active_desc] == ctl[`DMADC_CTL_CNT_MSB:0]);

// high level or rising edge requests
// level masked in holdoff; a pending level must not re-pend at grant
assign trig_event = chan_enable &
   (sw_trig | auto_trig |
    (ctl[`DMADC_CTL_LEVEL] ? (trig_s2 & ~hold_busy & ~chan_active & ~chan_request)
                           : (trig_s2 & ~trig_prev)));

assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
assign wr_desc  = aw_addr[4];
assign wr_word  = aw_addr[5:2];

dmadc_mover u_mover (
   .clk       (clk),
   .arst_n    (arst_n),
   .start     (mv_start),
   .src_addr  (cur_src),
   .dst_addr  (cur_dst),
   .src_size  (src_size),
   .dst_size  (dst_size),
   .elem_size (elem_size),
   .done      (mv_done),
   .err       (mv_err),
   .mem_req   (mem_req),
   .mem_write (mem_write),
   .mem_addr  (mem_addr),
   .mem_size  (mem_size),
   .mem_wdata (mem_wdata),
   .mem_ack   (mem_ack),
   .mem_rdata (mem_rdata),
   .mem_err   (mem_err)
);

// Trigger pin synchroniser; only trig_s2 and its delayed copy trig_prev are looked at
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      trig_s1   <= 1'b0;
      trig_s2   <= 1'b0;
      trig_prev <= 1'b0;
   end else begin
      trig_s1   <= channel_trigger_input;
      trig_s2   <= trig_s1;
      trig_prev <= trig_s2;
   end
end

// AXI4-Lite handshakes; address and data may arrive in either order
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DMADC_AXI_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `DMADC_AXI_OKAY;
      s_axi_rdata   <= `DMADC_RST_WORD;
      aw_hold       <= 1'b0;
      aw_addr       <= 6'h00;
      w_hold        <= 1'b0;
      w_data        <= `DMADC_RST_WORD;
      w_strb        <= 4'h0;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         aw_hold       <= 1'b1;
         aw_addr       <= s_axi_awaddr[5:0];
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_hold       <= 1'b1;
         w_data       <= s_axi_wdata;
         w_strb       <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end
      if (do_write) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= dmadc_mapped(aw_addr) ? `DMADC_AXI_OKAY : `DMADC_AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid  <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= dmadc_mapped(s_axi_araddr[5:0]) ? `DMADC_AXI_OKAY
            : `DMADC_AXI_SLVERR;
         if (s_axi_araddr[5] == 1'b0) begin
            case (s_axi_araddr[3:2])
               `DMADC_SLOT_SRC: s_axi_rdata <= desc_src[s_axi_araddr[4]];
               `DMADC_SLOT_DST: s_axi_rdata <= desc_dst[s_axi_araddr[4]];
               `DMADC_SLOT_CTL: s_axi_rdata <= desc_ctl[s_axi_araddr[4]];
               default: s_axi_rdata <= dmadc_status(st_valid[s_axi_araddr[4]],
                  st_resp[s_axi_araddr[4]],
                  st_index[s_axi_araddr[4]]);
            endcase
         end else begin
            case (s_axi_araddr[3:2])
               2'h0:    s_axi_rdata <= {30'h00000000, active_desc, chan_enable};
               2'h1:    s_axi_rdata <= {16'h0000, holdoff_cycles};
               2'h2:    s_axi_rdata <= {29'h00000000, hold_busy, chan_request,
                  chan_active};
               default: s_axi_rdata <= `DMADC_RST_WORD;
            endcase
         end
      end
      if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
end

// Level-trigger holdoff counter
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      hold_busy <= 1'b0;
      hold_cnt  <= 16'h0000;
   end else if (state == S_MOVE && mv_done && ctl[`DMADC_CTL_LEVEL] &&
                (last_elem || mode == `DMADC_MODE_SINGLE || mv_err)) begin
      hold_busy <= 1'b1;
      hold_cnt  <= 16'h0000;
   end else if (hold_busy) begin
      hold_cnt <= hold_cnt + 16'h0001;
      if (!trig_s2) begin
         hold_busy <= 1'b0;
      end else if (hold_cnt >= holdoff_cycles) begin
         hold_busy <= 1'b0;
      end
   end
end

// Channel engine and register storage
always @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      desc_src[0]    <= `DMADC_RST_WORD;
      desc_src[1]    <= `DMADC_RST_WORD;
      desc_dst[0]    <= `DMADC_RST_WORD;
      desc_dst[1]    <= `DMADC_RST_WORD;
      desc_ctl[0]    <= `DMADC_RST_WORD;
      desc_ctl[1]    <= `DMADC_RST_WORD;
      st_valid[0]    <= 1'b0;
      st_valid[1]    <= 1'b0;
      st_resp[0]     <= `DMADC_RESP_OK;
      st_resp[1]     <= `DMADC_RESP_OK;
      st_index[0]    <= 16'h0000;
      st_index[1]    <= 16'h0000;
      chan_enable    <= 1'b0;
      active_desc    <= 1'b0;
      holdoff_cycles <= `DMADC_RST_HOLDOFF;
      state          <= S_IDLE;
      cur_src        <= `DMADC_RST_WORD;
      cur_dst        <= `DMADC_RST_WORD;
      mv_start       <= 1'b0;
      chan_request   <= 1'b0;
      chan_active    <= 1'b0;
      complete_irq   <= 1'b0;
      auto_trig      <= 1'b0;
      sw_trig        <= 1'b0;
   end else begin
      mv_start     <= 1'b0;
      complete_irq <= 1'b0;
      auto_trig    <= 1'b0;
      sw_trig      <= 1'b0;
      case (state)
         S_IDLE: begin
            chan_active <= 1'b0;
            if (chan_request && engine_grant && chan_enable) begin
               chan_request <= 1'b0;
               if (st_valid[active_desc]) begin
                  state       <= S_MOVE;
                  chan_active <= 1'b1;
                  mv_start    <= 1'b1;
                  if (st_index[active_desc] == 16'h0000) begin
                     cur_src <= desc_src[active_desc];
                     cur_dst <= desc_dst[active_desc];
                  end
               end
            end
         end
         S_MOVE: begin
            if (mv_done) begin
               if (mv_err) begin
                  // Bus error aborts: descriptor parked invalid
                  st_resp[active_desc]  <= `DMADC_RESP_BUSERR;
                  st_valid[active_desc] <= 1'b0;
                  st_index[active_desc] <= 16'h0000;
                  state                 <= S_IDLE;
               end else begin
                  st_resp[active_desc] <= `DMADC_RESP_OK;
                  if (ctl[`DMADC_CTL_SINC]) begin
                     cur_src <= cur_src + dmadc_step(src_size);
                  end
                  if (ctl[`DMADC_CTL_DINC]) begin
                     cur_dst <= cur_dst + dmadc_step(dst_size);
                  end
                  if (last_elem) begin
                     st_index[active_desc] <= 16'h0000;
                     state                 <= S_IDLE;
                     if (ctl[`DMADC_CTL_INVAL]) begin
                        st_valid[active_desc] <= 1'b0;
                     end
                     complete_irq <= ctl[`DMADC_CTL_IRQ];
                     if (ctl[`DMADC_CTL_CHAIN]) begin
                        active_desc <= ~active_desc;
                     end
                     auto_trig <= (mode == `DMADC_MODE_CHAIN);
                  end else begin
                     st_index[active_desc] <= st_index[active_desc] + 16'h0001;
                     if (mode == `DMADC_MODE_SINGLE) begin
                        state <= S_IDLE;
                     end else if (ctl[`DMADC_CTL_PREEMPT] && preempt_req) begin
                        state <= S_IDLE;
                     end else begin
                        mv_start <= 1'b1;
                     end
                  end
               end
            end
         end
         default: state <= S_IDLE;
      endcase
      if (state == S_MOVE && mv_done && !mv_err && !last_elem &&
          mode != `DMADC_MODE_SINGLE && ctl[`DMADC_CTL_PREEMPT] && preempt_req) begin
         chan_request <= 1'b1;
      end
      // New trigger wins over the grant that clears pending
      if (trig_event) begin
         chan_request <= 1'b1;
      end
      // Bus writes last: a software set of validity wins over invalidate
      if (do_write && dmadc_mapped(aw_addr)) begin
         if (aw_addr[5] == 1'b0) begin
            case (wr_word[1:0])
               `DMADC_SLOT_SRC: desc_src[wr_desc] <= dmadc_merge(desc_src[wr_desc],
                  w_data, w_strb);
               `DMADC_SLOT_DST: desc_dst[wr_desc] <= dmadc_merge(desc_dst[wr_desc],
                  w_data, w_strb);
               `DMADC_SLOT_CTL: desc_ctl[wr_desc] <= dmadc_merge(desc_ctl[wr_desc],
                  w_data, w_strb);
               default: begin
                  if (w_strb[3]) begin
                     st_valid[wr_desc] <= w_data[`DMADC_ST_VALID];
                  end
               end
            endcase
         end else if (wr_word == 4'h8 && w_strb[0]) begin
            chan_enable <= w_data[`DMADC_CH_ENABLE];
            sw_trig     <= w_data[`DMADC_CH_SWTRIG];
            // Descriptor choice is frozen while a transfer runs
            if (state == S_IDLE) begin
               active_desc <= w_data[`DMADC_CH_ACTDESC];
            end
         end else if (wr_word == 4'h9) begin
            if (w_strb[0]) begin
               holdoff_cycles[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
               holdoff_cycles[15:8] <= w_data[15:8];
            end
         end
      end
   end
end

endmodule
`default_nettype wire

// File: shared/dmadc_map.vh
// Offsets, fields, encodings and reset values of the channel.
// Included by both design files; needs nothing else.
`ifndef DMADC_MAP_VH
`define DMADC_MAP_VH

// Byte offsets on the register bus
`define DMADC_OFF_DESC0     8'h00
`define DMADC_OFF_DESC1     8'h10
`define DMADC_OFF_CHCTL     8'h20
`define DMADC_OFF_HOLDOFF   8'h24
`define DMADC_OFF_CHSTAT    8'h28
// Word slots inside one descriptor
`define DMADC_SLOT_SRC      2'h0
`define DMADC_SLOT_DST      2'h1
`define DMADC_SLOT_CTL      2'h2
`define DMADC_SLOT_STAT     2'h3

// Control word fields
`define DMADC_CTL_CNT_MSB   15
`define DMADC_CTL_ESIZE_LSB 16
`define DMADC_CTL_SRCW      18
`define DMADC_CTL_DSTW      19
`define DMADC_CTL_SINC      20
`define DMADC_CTL_DINC      21
`define DMADC_CTL_LEVEL     22
`define DMADC_CTL_MODE_LSB  23
`define DMADC_CTL_PREEMPT   25
`define DMADC_CTL_CHAIN     26
`define DMADC_CTL_INVAL     27
`define DMADC_CTL_IRQ       28

// Status word fields
`define DMADC_ST_VALID      31
`define DMADC_ST_RESP_LSB   16
`define DMADC_RESP_OK       3'h0
`define DMADC_RESP_BUSERR   3'h1

// Channel control and channel status bits
`define DMADC_CH_ENABLE     0
`define DMADC_CH_ACTDESC    1
`define DMADC_CH_SWTRIG     2
`define DMADC_CS_BUSY       0
`define DMADC_CS_PEND       1
`define DMADC_CS_HOLD       2

// Encodings
`define DMADC_SIZE_8        2'h0
`define DMADC_SIZE_16       2'h1
`define DMADC_SIZE_32       2'h2
`define DMADC_MODE_SINGLE   2'h0
`define DMADC_MODE_DESC     2'h1
`define DMADC_MODE_CHAIN    2'h2
`define DMADC_AXI_OKAY      2'h0
`define DMADC_AXI_SLVERR    2'h2

// Reset values
`define DMADC_RST_WORD      32'h00000000
`define DMADC_RST_HOLDOFF   16'h0000

`endif

// File: test/dmadc_chk.sv
// Checker on the channel top's ports.
// Bound in at the foot.
`default_nettype none
module dmadc_chk (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        mem_req,
   input wire logic        mem_write,
   input wire logic [31:0] mem_addr,
   input wire logic        mem_ack,
   input wire logic        mem_err,
   input wire logic        chan_active,
   input wire logic        complete_irq,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_arready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   property p_hold; mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_write); endproperty
   a_hold: assert property (p_hold) else $error("request changed before ack");
   property p_rd_wr; mem_req && !mem_write && mem_ack && !mem_err |=> mem_req && mem_write; endproperty
   a_rd_wr: assert property (p_rd_wr) else $error("read not followed by write");
   property p_gap; mem_req && mem_write && mem_ack |=> !mem_req [*2]; endproperty
   a_gap: assert property (p_gap) else $error("no gap after element");
   property p_irq; complete_irq |=> !complete_irq; endproperty
   a_irq: assert property (p_irq) else $error("completion pulse too long");
   property p_irq_act; complete_irq |-> chan_active; endproperty
   a_irq_act: assert property (p_irq_act) else $error("completion while idle");
   property p_req_act; mem_req |-> chan_active; endproperty
   a_req_act: assert property (p_req_act) else $error("access while not active");
   property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_b: assert property (p_b) else $error("write response dropped");
   property p_r; s_axi_rvalid |-> !s_axi_arready; endproperty
   a_r: assert property (p_r) else $error("second read taken");
endmodule
bind dmadc_top dmadc_chk u_chk (.*);
`default_nettype wire

// File: test/dmadc_mem_model.sv
// Memory target on the channel's port, logging accesses.
// Assumes one request at a time, held until acknowledged.
`default_nettype none
module dmadc_mem_model (
   input  wire logic        clk,
   input  wire logic        arst_n,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output var  logic        mem_ack,
   output var  logic [31:0] mem_rdata,
   output var  logic [31:0] last_raddr,
   output var  logic [31:0] last_waddr,
   output var  logic [31:0] last_wdata,
   output var  logic [7:0]  n_writes
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] waits;
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_ack <= 1'b0;
         mem_rdata <= 32'h0;
         waits <= 2'h0;
         n_writes <= 8'h0;
      end else begin
         mem_ack <= 1'b0;
         // Read data is garbage outside an ack
         mem_rdata <= ~mem_rdata;
         if (mem_req && !mem_ack) begin
            waits <= waits + 2'h1;
            if (waits == (slow ? 2'h3 : 2'h0)) begin
               mem_ack <= 1'b1;
               waits <= 2'h0;
               if (mem_write) begin
                  last_waddr <= mem_addr;
                  last_wdata <= mem_wdata;
                  n_writes <= n_writes + 8'h1;
               end else begin
                  last_raddr <= mem_addr;
                  mem_rdata <= ~mem_addr;
               end
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: test/test_dma_descriptor_control.sv
// Bench: registers over AXI4-Lite, transfers into a memory model.
// Assumes the map header is on the include path.
`default_nettype none
`include "dmadc_map.vh"
module test_dma_descriptor_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, channel_trigger_input = 0, slow = 0;
   logic engine_grant = 1, preempt_req = 0, mem_err = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   logic [3:0] s_axi_wstrb = 4'hf;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mem_ack;
   wire chan_request, chan_active, complete_irq, mem_req, mem_write;
   wire [1:0] s_axi_bresp, s_axi_rresp, mem_size;
   wire [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, last_raddr, last_waddr, last_wdata;
   wire [7:0] n_writes;
   int n_mismatch = 0, checks_done = 0;
   always #10 clk = ~clk;
   dmadc_top dut_u (.*);
   dmadc_mem_model mem_u (.*);
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task report_and_stop();
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rsp = 0);
      bit done = 0;
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata} <= {a, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      while (!done) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) begin
            done = 1;
            s_axi_bready <= 0;
            chk(s_axi_bresp, rsp);
         end
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] rsp = 0);
      bit done = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      while (!done) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) begin
            done = 1;
            s_axi_rready <= 0;
            chk(s_axi_rdata & m, e);
            chk(s_axi_rresp, rsp);
         end
      end
   endtask
   task desc(input logic [7:0] b, input logic [31:0] s, d, c);
      wr(b, s);
      wr(b + 8'h4, d);
      wr(b + 8'h8, c);
      wr(b + 8'hc, 32'h8000_0000);
   endtask
   task wait_wr(input logic [7:0] n);
      while (n_writes !== n) @(posedge clk);
   endtask
   task sc_regs();
      rdchk(`DMADC_OFF_DESC0 + 8'h8, '1, 0);
      rdchk(`DMADC_OFF_CHCTL, '1, 0);
      wr(`DMADC_OFF_DESC1, 32'h1234_5678);
      rdchk(`DMADC_OFF_DESC1, '1, 32'h1234_5678);
      wr(8'h30, '1, `DMADC_AXI_SLVERR);
      rdchk(8'h30, '1, 0, `DMADC_AXI_SLVERR);
      wr(`DMADC_OFF_DESC0 + 8'hc, '1);
      rdchk(`DMADC_OFF_DESC0 + 8'hc, '1, 32'h8000_0000);
   endtask
   // Three words, stepping, invalidate, irq; not preemptable
   task sc_block();
      desc(`DMADC_OFF_DESC0, 32'h1000, 32'h2000, 32'h18be_0002);
      wr(`DMADC_OFF_CHCTL, 32'h1);
      preempt_req <= 1;
      channel_trigger_input <= 1;
      repeat (3) @(posedge clk);
      channel_trigger_input <= 0;
      while (chan_active !== 1'b1) @(posedge clk);
      engine_grant <= 0;
      while (complete_irq !== 1'b1) @(posedge clk);
      chk(n_writes, 3);
      chk(last_raddr, 32'h1008);
      chk(last_waddr, 32'h2008);
      chk(last_wdata, ~32'h1008);
      {engine_grant, preempt_req} <= 2'h2;
      rdchk(`DMADC_OFF_DESC0 + 8'hc, 32'h8000_0000, 0);
   endtask
   task sc_single();
      slow <= 1;
      desc(`DMADC_OFF_DESC1, 32'h3000, 32'h4000, 32'h0010_0001);
      wr(`DMADC_OFF_CHCTL, 32'h7);
      wait_wr(4);
      chk(last_raddr, 32'h3000);
      wr(`DMADC_OFF_CHCTL, 32'h7);
      wait_wr(5);
      chk(last_raddr, 32'h3001);
      chk(last_waddr, 32'h4000);
      rdchk(`DMADC_OFF_DESC1 + 8'hc, 32'h8000_0000, 32'h8000_0000);
   endtask
   task sc_chain();
      slow <= 0;
      desc(`DMADC_OFF_DESC0, 32'h5000, 32'h6000, 32'h0502_0000);
      desc(`DMADC_OFF_DESC1, 32'h7000, 32'h8000, 32'h0082_0000);
      wr(`DMADC_OFF_CHCTL, 32'h5);
      wait_wr(7);
      chk(last_waddr, 32'h8000);
      rdchk(`DMADC_OFF_CHCTL, 32'h3, 32'h3);
      wr(`DMADC_OFF_DESC1 + 8'hc, 32'h0);
      wr(`DMADC_OFF_CHCTL, 32'h7);
      repeat (30) @(posedge clk);
      chk(n_writes, 7);
   endtask
   task sc_preempt();
      desc(`DMADC_OFF_DESC1, 32'h9000, 32'ha000, 32'h02a2_0003);
      preempt_req <= 1;
      wr(`DMADC_OFF_CHCTL, 32'h7);
      wait_wr(8);
      engine_grant <= 0;
      repeat (10) @(posedge clk);
      chk(n_writes, 8);
      chk(32'(chan_request), 1);
      {engine_grant, preempt_req} <= 2'h2;
      wait_wr(11);
      chk(last_waddr, 32'ha00c);
   endtask
   // Level trigger, single mode, 16-bit elements, holdoff 40
   task sc_level();
      desc(`DMADC_OFF_DESC0, 32'hb000, 32'hc000, 32'h0051_0003);
      wr(`DMADC_OFF_HOLDOFF, 32'h28);
      wr(`DMADC_OFF_CHCTL, 32'h1);
      channel_trigger_input <= 1;
      wait_wr(12);
      repeat (20) @(posedge clk);
      chk(n_writes, 12);
      wait_wr(13);
      chk(last_raddr, 32'hb002);
      channel_trigger_input <= 0;
      repeat (4) @(posedge clk);
      channel_trigger_input <= 1;
      while (mem_req !== 1'b1) @(posedge clk);
      chk(mem_size, `DMADC_SIZE_16);
      channel_trigger_input <= 0;
      repeat (20) @(posedge clk);
      chk(n_writes, 14);
   endtask
   // Whole run is a few hundred cycles
   initial begin
      #200us;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1;
      sc_regs();
      sc_block();
      sc_single();
      sc_chain();
      sc_preempt();
      sc_level();
      report_and_stop();
   end
endmodule
`default_nettype wire
